// >>> rtl/dmx_pkg.sv
// Package of constants and carrier types for the data-move executor
package dmx_pkg;
  // ---------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------
  localparam logic [3:0] OPC_MOVE_SRC = 4'hC;   // 1100, first word
  localparam logic [3:0] OPC_MOVE_DST = 4'hF;   // 1111, second word
  localparam logic [7:0] OPC_BANK_LOAD = 8'h01; // 0000 0001
  localparam logic [7:0] OPC_WORK_LOAD = 8'h0E; // 0000 1110
  localparam logic [6:0] OPC_WORK_STORE = 7'h37; // 0110 111
  localparam int ACC_BIT = 8;

  // ---------------------------------------------------------------
  // Data space layout
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] WORK_ADDR = 12'hFE8;    // Working register location
  localparam logic [ADDR_W-1:0] STAT_ADDR = 12'hFD8;    // Flag register location
  localparam logic [ADDR_W-1:0] PCL_ADDR = 12'hFF9;
  localparam logic [ADDR_W-1:0] STACK_TOP_LOW_ADDR = 12'hFFD;
  localparam logic [ADDR_W-1:0] STACK_TOP_HIGH_ADDR = 12'hFFE;
  localparam logic [ADDR_W-1:0] STACK_TOP_UPPER_ADDR = 12'hFFF;
  localparam logic [7:0] ACC_SPLIT = 8'h80;             // Low access half ends below this
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [3:0] ACC_LO_BANK = 4'h0;
  localparam logic [7:0] BANK_RST = 8'h00;
  localparam logic [7:0] WORK_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;

  // Instruction word with a qualifier
  typedef struct packed {
    logic valid;
    logic [15:0] word;
  } dmx_instr_t;

  // Data memory write request
  typedef struct packed {
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } dmx_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DEST = 2'b01,
    ST_HOLD = 2'b11
  } dmx_state_t;
endpackage : dmx_pkg

// >>> rtl/dmx_exec.sv
// Decode and execute logic for four data-move instructions
`timescale 1ns/1ps
module dmx_exec (
  input wire logic clock,
  input wire logic srst,
  input wire dmx_pkg::dmx_instr_t instr,
  input wire logic stall,
  input wire logic [dmx_pkg::DATA_W-1:0] rd_data,
  output logic rd_en,
  output logic [dmx_pkg::ADDR_W-1:0] rd_addr,
  output dmx_pkg::dmx_wr_t wr,
  output logic [dmx_pkg::DATA_W-1:0] work_reg,
  output logic [dmx_pkg::DATA_W-1:0] bank_select_reg,
  output logic [dmx_pkg::DATA_W-1:0] status_reg,
  output logic busy,
  output logic illegal_dest
);
  import dmx_pkg::*;

  dmx_state_t state_q;
  logic [DATA_W-1:0] src_byte_q;
  logic src_is_work_q;
  logic [ADDR_W-1:0] dst_addr_d;
  logic [ADDR_W-1:0] file_addr_d;
  logic [DATA_W-1:0] move_byte_d;
  logic is_move_src;
  logic is_move_dst;
  logic is_bank_load;
  logic is_work_load;
  logic is_work_store;
  logic [15:0] w;

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  // Every decode is gated by the state, so a stray word in mid-move does nothing
  assign w = instr.word;
  assign is_move_src = instr.valid && state_q == ST_IDLE && w[15:12] == OPC_MOVE_SRC;
  // The second word is taken in the wait state too, once the stall lifts
  assign is_move_dst = instr.valid && (state_q == ST_DEST || state_q == ST_HOLD)
                       && w[15:12] == OPC_MOVE_DST;
  assign is_bank_load = instr.valid && state_q == ST_IDLE && w[15:8] == OPC_BANK_LOAD;
  assign is_work_load = instr.valid && state_q == ST_IDLE && w[15:8] == OPC_WORK_LOAD;
  assign is_work_store = instr.valid && state_q == ST_IDLE && w[15:9] == OPC_WORK_STORE;

  // Banked target of the store; access bank splits low RAM and top SFRs
  always_comb begin
    if (w[ACC_BIT]) begin
      file_addr_d = {bank_select_reg[3:0], w[7:0]};
    end else if (w[7:0] < ACC_SPLIT) begin
      file_addr_d = {ACC_LO_BANK, w[7:0]};
    end else begin
      file_addr_d = {ACC_HI_BANK, w[7:0]};
    end
  end

  // Destination is the full 12-bit field, bank select plays no part
  assign dst_addr_d = w[ADDR_W-1:0];
  // Working register is not in the memory, so a move from it uses the live value.
  // Read data is used straight from the port while rd_en stands; a stalled move
  // falls back to the captured copy, since the memory may drive something else then.
  assign move_byte_d = src_is_work_q ? work_reg : (rd_en ? rd_data : src_byte_q);

  // ---------------------------------------------------------------
  // Move sequencer
  // ---------------------------------------------------------------
  // Stall parks the move in the wait state, giving the three-cycle case.
  // The wait state still takes the second word as soon as the stall lifts,
  // so one stalled cycle costs exactly one extra instruction cycle.
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (is_move_src) begin
            state_q <= ST_DEST;
          end
        end
        ST_DEST: begin
          if (stall) begin
            state_q <= ST_HOLD;
          end else if (is_move_dst) begin
            state_q <= ST_IDLE;
          end
        end
        ST_HOLD: begin
          if (!stall && is_move_dst) begin
            state_q <= ST_IDLE;
          end else if (!stall) begin
            state_q <= ST_DEST;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Source read issued in the cycle after the first word; the byte is on rd_data while rd_en stands.
  // The working register is not in the memory, so no read is issued for it.
  always_ff @(posedge clock) begin
    if (srst) begin
      rd_en <= 1'b0;
      rd_addr <= '0;
      src_is_work_q <= 1'b0;
    end else begin
      rd_en <= is_move_src && w[ADDR_W-1:0] != WORK_ADDR;
      if (is_move_src) begin
        rd_addr <= w[ADDR_W-1:0];
        src_is_work_q <= w[ADDR_W-1:0] == WORK_ADDR;
      end
    end
  end

  // Keep the read byte for a move whose second word is held back by a stall;
  // an unstalled move whose second word follows at once never waits for this copy
  always_ff @(posedge clock) begin
    if (srst) begin
      src_byte_q <= '0;
    end else if (rd_en) begin
      src_byte_q <= rd_data;
    end
  end

  // ---------------------------------------------------------------
  // Write port
  // ---------------------------------------------------------------
  // Unsupported move targets are dropped and flagged, not written.
  // Working and flag register targets stay inside the block, so the
  // memory never sees a write that would shadow them.
  always_ff @(posedge clock) begin
    if (srst) begin
      wr <= '0;
      illegal_dest <= 1'b0;
    end else begin
      wr.we <= 1'b0;
      illegal_dest <= 1'b0;
      if (is_move_dst && !stall) begin
        if (dst_addr_d == PCL_ADDR || dst_addr_d == STACK_TOP_LOW_ADDR || dst_addr_d == STACK_TOP_HIGH_ADDR
            || dst_addr_d == STACK_TOP_UPPER_ADDR) begin
          illegal_dest <= 1'b1;
        end else if (dst_addr_d != WORK_ADDR && dst_addr_d != STAT_ADDR) begin
          wr.we <= 1'b1;
          wr.addr <= dst_addr_d;
          wr.data <= move_byte_d;
        end
      end else if (is_work_store) begin
        if (file_addr_d != WORK_ADDR && file_addr_d != STAT_ADDR) begin
          wr.we <= 1'b1;
          wr.addr <= file_addr_d;
          wr.data <= work_reg;
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Core registers
  // ---------------------------------------------------------------
  // Working register: literal load or an explicit move into it.
  // A store aimed at its own address would copy it onto itself, so it is left out.
  always_ff @(posedge clock) begin
    if (srst) begin
      work_reg <= WORK_RST;
    end else if (is_work_load) begin
      work_reg <= w[7:0];
    end else if (is_move_dst && !stall && dst_addr_d == WORK_ADDR) begin
      work_reg <= move_byte_d;
    end
  end

  // Bank select register
  // Only the low nibble reaches an address; the full byte is kept as loaded
  always_ff @(posedge clock) begin
    if (srst) begin
      bank_select_reg <= BANK_RST;
    end else if (is_bank_load) begin
      bank_select_reg <= w[7:0];
    end
  end

  // Flags change only when named as the explicit target
  // Nothing here computes a result, so no flag is ever derived from data
  always_ff @(posedge clock) begin
    if (srst) begin
      status_reg <= STAT_RST;
    end else if (is_move_dst && !stall && dst_addr_d == STAT_ADDR) begin
      status_reg <= move_byte_d;
    end else if (is_work_store && file_addr_d == STAT_ADDR) begin
      status_reg <= work_reg;
    end
  end

  // Busy while the second move word is awaited
  // Tracks the sequencer being out of idle, so it also covers the wait state
  always_ff @(posedge clock) begin
    if (srst) begin
      busy <= 1'b0;
    end else begin
      busy <= is_move_src || (state_q != ST_IDLE && !(is_move_dst && !stall));
    end
  end
endmodule : dmx_exec

// >>> verification/dmx_exec_monitor.sv
// Concurrent checks on the data-move executor ports
`timescale 1ns/1ps
module dmx_exec_monitor (
  input wire logic clock,
  input wire logic srst,
  input wire dmx_pkg::dmx_instr_t instr,
  input wire logic stall,
  input wire logic [dmx_pkg::DATA_W-1:0] rd_data,
  input wire logic rd_en,
  input wire logic [dmx_pkg::ADDR_W-1:0] rd_addr,
  input wire dmx_pkg::dmx_wr_t wr,
  input wire logic [dmx_pkg::DATA_W-1:0] work_reg,
  input wire logic [dmx_pkg::DATA_W-1:0] bank_select_reg,
  input wire logic [dmx_pkg::DATA_W-1:0] status_reg,
  input wire logic busy,
  input wire logic illegal_dest
);
  import dmx_pkg::*;
  // Decode helpers: idle take, second move word, forbidden target
  wire [15:0] w = instr.word;
  wire go = instr.valid && !busy;
  wire d2 = instr.valid && busy && !stall && w[15:12] == OPC_MOVE_DST;
  wire bad = w[11:0] == PCL_ADDR || w[11:0] >= STACK_TOP_LOW_ADDR;
  wire st = go && w[15:9] == OPC_WORK_STORE;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  a_src_read: assert property (go && w[15:12] == OPC_MOVE_SRC && w[11:0] != WORK_ADDR
    |=> rd_en && rd_addr == $past(w[11:0])) else $error("source read wrong");
  a_move_write: assert property (d2 && !bad && w[11:0] != WORK_ADDR && w[11:0] != STAT_ADDR
    |=> wr.we && wr.addr == $past(w[11:0])) else $error("move write wrong");
  a_illegal_drop: assert property (d2 && bad |=> illegal_dest && !wr.we) else $error("bad target written");
  a_bank_load: assert property (go && w[15:8] == OPC_BANK_LOAD
    |=> bank_select_reg == $past(w[7:0])) else $error("bank load wrong");
  a_work_load: assert property (go && w[15:8] == OPC_WORK_LOAD
    |=> work_reg == $past(w[7:0])) else $error("work load wrong");
  a_store_access: assert property (st && !w[ACC_BIT] && w[7:0] < ACC_SPLIT
    |=> wr.we && wr.addr == {4'h0, $past(w[7:0])} && wr.data == $past(work_reg)) else $error("access store");
  a_store_banked: assert property (st && w[ACC_BIT] && bank_select_reg[3:0] != 4'hF
    |=> wr.addr == {$past(bank_select_reg[3:0]), $past(w[7:0])}) else $error("banked store");
  a_flag_hold: assert property (!$stable(status_reg)
    |-> $past(d2 && w[11:0] == STAT_ADDR) || $past(st)) else $error("flags changed");
  a_stall_hold: assert property (busy && stall |=> busy && !wr.we) else $error("stall ignored");
endmodule : dmx_exec_monitor
bind dmx_exec dmx_exec_monitor u_mon (.clock, .srst, .instr, .stall, .rd_data, .rd_en, .rd_addr, .wr,
  .work_reg, .bank_select_reg, .status_reg, .busy, .illegal_dest);

// >>> verification/data_move_instruction_exec_bench.sv
// Self-checking bench for the data-move executor
`timescale 1ns/1ps
module data_move_instruction_exec_bench;
  import dmx_pkg::*;
  logic clock = 1'b0, srst = 1'b1, stall = 1'b0;
  dmx_instr_t instr = '0;
  logic [7:0] rd_data = 8'h33;
  logic rd_en, busy, illegal_dest;
  logic [11:0] rd_addr;
  dmx_wr_t wr;
  logic [7:0] work_reg, bank_select_reg, status_reg;
  int fails = 0, total_checks = 0;
  // Core clock, 10 ns period
  always #5 clock = ~clock;
  dmx_exec DUT (.clock, .srst, .instr, .stall, .rd_data, .rd_en, .rd_addr, .wr, .work_reg,
    .bank_select_reg, .status_reg, .busy, .illegal_dest);
  // Case-equal compare, so an unknown never matches
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // Offer a word at a falling edge; results are settled on return
  task automatic op(input logic v, input logic [15:0] w);
    instr = {v, w};
    @(negedge clock);
  endtask : op
  // Counts, verdict and end of run, shared by the main sequence and the watchdog
  task automatic print_verdict;
    $display("checks=%0d fails=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  // Literal loads, then a foreign opcode that must leave work alone
  task automatic t_literals;
    op(1'b1, 16'h0105);
    chk(bank_select_reg, 12'h05);
    op(1'b1, 16'h0E5A);
    chk(work_reg, 12'h5A);
    op(1'b1, 16'h0D77);
    chk(work_reg, 12'h5A);
    chk(bank_select_reg, 12'h05);
  endtask : t_literals
  // Back-to-back stores: both access halves, then banked at the top byte
  task automatic t_store;
    op(1'b1, 16'h6E20);
    chk(wr.we, 12'h1);
    chk(wr.addr, 12'h020);
    chk(wr.data, 12'h5A);
    op(1'b1, 16'h6E90);
    chk(wr.we, 12'h1);
    chk(wr.addr, 12'hF90);
    op(1'b1, 16'h6FFF);
    chk(wr.addr, 12'h5FF);
    chk(wr.data, 12'h5A);
    op(1'b0, 16'h0000);
    chk(wr.we, 12'h0);
    chk(status_reg, 12'h00);
  endtask : t_store
  // Moves: plain, via work, forbidden target, stalled, into the flags.
  // No move here aims at interrupt setup.
  task automatic t_move;
    op(1'b1, 16'hC123);
    chk(rd_en, 12'h1);
    chk(rd_addr, 12'h123);
    chk(busy, 12'h1);
    op(1'b1, 16'hF456);
    chk(wr.we, 12'h1);
    chk(wr.addr, 12'h456);
    chk(wr.data, 12'h33);
    chk(rd_en, 12'h0);
    chk(busy, 12'h0);
    op(1'b1, 16'hCFFF);
    op(1'b1, 16'hFFE8);
    chk(work_reg, 12'h33);
    rd_data = 8'hC4;
    op(1'b1, 16'hCFE8);
    chk(rd_en, 12'h0);
    op(1'b1, 16'hF800);
    chk(wr.data, 12'h33);
    rd_data = 8'h33;
    op(1'b1, 16'hC010);
    op(1'b1, 16'hFFF9);
    chk(illegal_dest, 12'h1);
    chk(wr.we, 12'h0);
    op(1'b1, 16'hC011);
    stall = 1'b1;
    op(1'b1, 16'hF7AB);
    chk(wr.we, 12'h0);
    chk(busy, 12'h1);
    stall = 1'b0;
    rd_data = 8'hC4;
    op(1'b1, 16'hF7AB);
    chk(wr.we, 12'h1);
    chk(wr.addr, 12'h7AB);
    chk(wr.data, 12'h33);
    chk(busy, 12'h0);
    rd_data = 8'h33;
    op(1'b1, 16'hC012);
    op(1'b1, 16'hFFD8);
    chk(status_reg, 12'h33);
    op(1'b0, 16'h0000);
  endtask : t_move
  // Reset in mid-move: registers clear, and a stray second word after release does nothing
  task automatic t_reset;
    op(1'b1, 16'hC0AA);
    srst = 1'b1;
    op(1'b1, 16'hF0BB);
    op(1'b0, 16'h0000);
    chk(busy, 12'h0);
    chk(wr.we, 12'h0);
    chk(work_reg, WORK_RST);
    chk(bank_select_reg, BANK_RST);
    chk(status_reg, STAT_RST);
    srst = 1'b0;
    op(1'b1, 16'hF0BB);
    chk(wr.we, 12'h0);
    chk(busy, 12'h0);
    chk(illegal_dest, 12'h0);
  endtask : t_reset
  // Main sequence: 10 cycles of reset, then the scenarios
  initial begin
    repeat (10) @(negedge clock);
    srst = 1'b0;
    t_literals();
    t_store();
    t_move();
    t_reset();
    print_verdict();
  end
  // Watchdog far past the some 35 cycles of reset and stimulus
  initial begin
    #5000;
    fails++;
    print_verdict();
  end
endmodule : data_move_instruction_exec_bench
